// >>> core/ext_bus_ctrl.sv
// external memory bus control: pin ownership, wait states and 16-bit write lane steering
//
// Overview of operation
// - in single-chip program memory mode the control register is disabled and writes are dropped.
// - with bus_release_select at 0 the bus owns the shared pins all the time and port I/O is off.
// - with bus_release_select at 1 the pins are port I/O except while an external access runs.
// - bus_release_select reads 0 after reset, so the bus owns the pins by default.
// - the wait field adds 0, 1, 2 or 3 instruction cycles for codes 11, 10, 01 and 00.
// - the write style field acts only on a 16-bit bus and is ignored in 8-bit mode.
// - word write style drives the latch as a full word and pulses the upper write strobe.
// - byte select style copies the byte to both lanes with upper strobe and one byte select.
// - byte write style copies the byte to both lanes with either the upper or lower strobe.
// - on the smallest package the control register is absent and reads as zero.
`timescale 1ns/1ps

module ext_bus_ctrl #(
    parameter int ADDR_W   = 20,
    parameter int TCY_CLKS = ext_bus_pkg::TCY_CLKS_DEFAULT
) (
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // register port
    input  wire logic [3:0]              reg_addr_in,
    input  wire logic [7:0]              reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic [7:0]                   reg_rdata_out,
    // device configuration levels
    input  wire logic                    single_chip_mode_in,
    input  wire logic                    small_package_in,
    input  wire logic                    bus_16bit_in,
    // core side table accesses
    input  wire logic                    table_read_op_in,
    input  wire logic                    table_write_op_in,
    input  wire logic [ADDR_W-1:0]       table_addr_in,
    input  wire logic [7:0]              table_latch_byte_in,
    output logic                         busy_out,
    output logic [7:0]                   read_data_out,
    output logic                         read_valid_out,
    // external bus side
    input  wire logic [15:0]             ext_data_in,
    output logic [15:0]                  ext_data_out,
    output logic                         ext_data_oe_n_out,
    output logic [ADDR_W-1:0]            ext_addr_out,
    output logic                         bus_owns_pins_out,
    output logic                         read_strobe_out,
    output logic                         upper_write_strobe_out,
    output logic                         lower_write_strobe_out,
    output logic                         upper_byte_select_out,
    output logic                         lower_byte_select_out
);

    // ======
    // declarations
    // ======
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_DONE
    } cycle_state_t;

    cycle_state_t             state_r;
    cycle_state_t             state_nxt;
    logic [7:0]               bus_ctrl_r;
    ext_bus_pkg::table_req_t  req_r;
    ext_bus_pkg::table_req_t  req_in;
    ext_bus_pkg::bus_strobes_t strobes_r;
    ext_bus_pkg::bus_strobes_t strobes_nxt;
    logic [15:0]              data_nxt;
    logic [7:0]               word_low_r;
    logic                     word_held_r;
    logic                     reg_locked;
    logic                     release_sel;
    logic [1:0]               wait_tcy;
    ext_bus_pkg::write_style_t style;
    logic                     start_cycle;
    logic                     stretch_done;
    logic                     launch;
    logic                     owns_nxt;

    // ======
    // helpers
    // ======
    // wait code to added instruction cycles: 11 adds none, 00 adds three
    function automatic logic [1:0] wait_cycles(input logic [1:0] code);
        wait_cycles = ext_bus_pkg::STRETCH_MAX_TCY - code;
    endfunction : wait_cycles

    // true for either word-write encoding of the style field
    function automatic logic is_word_style(input ext_bus_pkg::write_style_t s);
        is_word_style = (s == ext_bus_pkg::STYLE_WORD_A) || (s == ext_bus_pkg::STYLE_WORD_B);
    endfunction : is_word_style

    // ======
    // control decode
    // ======
    // register is gone on the small package and frozen in single-chip mode
    assign reg_locked  = single_chip_mode_in || small_package_in;
    assign release_sel = bus_ctrl_r[ext_bus_pkg::BIT_RELEASE];
    assign wait_tcy    = wait_cycles({bus_ctrl_r[ext_bus_pkg::BIT_STRETCH_HI],
                                      bus_ctrl_r[ext_bus_pkg::BIT_STRETCH_LO]});
    assign style       = ext_bus_pkg::write_style_t'({bus_ctrl_r[ext_bus_pkg::BIT_STYLE_HI],
                                                      bus_ctrl_r[ext_bus_pkg::BIT_STYLE_LO]});

    // collect the core request into one bundle
    assign req_in.write     = table_write_op_in;
    assign req_in.high_byte = table_addr_in[0];
    assign req_in.data      = table_latch_byte_in;
    assign req_in.addr      = table_addr_in;

    // a word-style write of the low byte is only held; the high byte launches the word
    assign launch = (table_read_op_in || table_write_op_in) && (state_r == ST_IDLE)
                    && !(table_write_op_in && bus_16bit_in && is_word_style(style)
                         && !table_addr_in[0]);

    // ======
    // control register
    // ======
    // only implemented bits store; writes while locked are dropped
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bus_ctrl_r <= ext_bus_pkg::CTRL_RESET;
        end else if (reg_wr_in && !reg_locked
                     && reg_addr_in == ext_bus_pkg::OFF_BUS_CTRL) begin
            bus_ctrl_r <= reg_wdata_in & ext_bus_pkg::CTRL_WRITE_MASK;
        end
    end

    // ======
    // register read port
    // ======
    // data appear one cycle after the read strobe and are zero otherwise
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                ext_bus_pkg::OFF_BUS_CTRL: begin
                    reg_rdata_out <= small_package_in ? 8'h00 : bus_ctrl_r;
                end
                ext_bus_pkg::OFF_BUS_STATUS: begin
                    reg_rdata_out <= {4'h0, reg_locked, word_held_r,
                                      bus_owns_pins_out, busy_out};
                end
                default: begin
                    reg_rdata_out <= 8'h00;   // unmapped offsets read zero
                end
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ======
    // word write low byte holding
    // ======
    // the low half of a word waits here until the high half arrives
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            word_low_r  <= 8'h00;
            word_held_r <= 1'b0;
        end else if (table_write_op_in && state_r == ST_IDLE && bus_16bit_in
                     && is_word_style(style)) begin
            if (!table_addr_in[0]) begin
                word_low_r  <= table_latch_byte_in;
                word_held_r <= 1'b1;
            end else begin
                word_held_r <= 1'b0;
            end
        end
    end

    // ======
    // wait state timer
    // ======
    assign start_cycle = launch;

    stretch_timer #(
        .TCY_CLKS    (TCY_CLKS)
    ) u_stretch (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .start_in    (start_cycle),
        .wait_tcy_in (wait_tcy),
        .done_out    (stretch_done)
    );

    // ======
    // bus cycle sequencer
    // ======
    // strobes stay asserted through the whole stretch, ending when the timer expires
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (launch) begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (stretch_done) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // request bundle is captured at launch so the core may move on
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            req_r <= '0;
        end else if (launch) begin
            req_r <= req_in;
        end
    end

    // ======
    // lane and strobe steering
    // ======
    // decided at launch from the live request and style
    always_comb begin
        strobes_nxt = ext_bus_pkg::STROBES_IDLE;
        data_nxt    = 16'h0000;
        if (!table_write_op_in) begin
            strobes_nxt.read = 1'b1;
        end else if (!bus_16bit_in) begin
            // 8-bit bus: style bits are ignored, one write strobe
            data_nxt                = {8'h00, table_latch_byte_in};
            strobes_nxt.lower_write = 1'b1;
        end else if (is_word_style(style)) begin
            data_nxt                = {table_latch_byte_in, word_low_r};
            strobes_nxt.upper_write = 1'b1;
        end else if (style == ext_bus_pkg::STYLE_BYTE_SELECT) begin
            data_nxt                 = {table_latch_byte_in, table_latch_byte_in};
            strobes_nxt.upper_write  = 1'b1;
            strobes_nxt.upper_select = table_addr_in[0];
            strobes_nxt.lower_select = !table_addr_in[0];
        end else begin
            data_nxt                = {table_latch_byte_in, table_latch_byte_in};
            strobes_nxt.upper_write = table_addr_in[0];
            strobes_nxt.lower_write = !table_addr_in[0];
        end
    end

    // drive the bus outputs during the active phase only
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            strobes_r         <= ext_bus_pkg::STROBES_IDLE;
            ext_data_out      <= 16'h0000;
            ext_data_oe_n_out <= 1'b1;
            ext_addr_out      <= '0;
        end else if (launch) begin
            strobes_r         <= strobes_nxt;
            ext_data_out      <= data_nxt;
            ext_data_oe_n_out <= !table_write_op_in;   // low while we drive data
            ext_addr_out      <= table_addr_in;
        end else if (state_r == ST_ACTIVE && stretch_done) begin
            strobes_r         <= ext_bus_pkg::STROBES_IDLE;
            ext_data_oe_n_out <= 1'b1;
        end
    end

    assign read_strobe_out        = strobes_r.read;
    assign upper_write_strobe_out = strobes_r.upper_write;
    assign lower_write_strobe_out = strobes_r.lower_write;
    assign upper_byte_select_out  = strobes_r.upper_select;
    assign lower_byte_select_out  = strobes_r.lower_select;

    // ======
    // read data capture
    // ======
    // sampled in the last stretched clock, so slow parts get the full wait time
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            read_data_out  <= 8'h00;
            read_valid_out <= 1'b0;
        end else if (state_r == ST_ACTIVE && stretch_done && !req_r.write) begin
            read_data_out  <= (bus_16bit_in && req_r.high_byte) ? ext_data_in[15:8]
                                                                : ext_data_in[7:0];
            read_valid_out <= 1'b1;
        end else begin
            read_valid_out <= 1'b0;
        end
    end

    // ======
    // pin ownership and busy
    // ======
    // released pins return to port I/O as soon as the access finishes
    assign owns_nxt = !release_sel
                      || (state_nxt == ST_ACTIVE);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bus_owns_pins_out <= 1'b1;
            busy_out          <= 1'b0;
        end else begin
            bus_owns_pins_out <= owns_nxt;
            busy_out          <= (state_nxt != ST_IDLE);
        end
    end

endmodule : ext_bus_ctrl

// >>> core/ext_bus_pkg.sv
// shared constants, types and register layout for the external memory bus control block
package ext_bus_pkg;

    // ======
    // register map
    // ======
    localparam logic [3:0] REG_ADDR_W        = 4'h4;
    localparam logic [3:0] OFF_BUS_CTRL      = 4'h0;   // external_bus_control
    localparam logic [3:0] OFF_BUS_STATUS    = 4'h1;   // live state of the bus engine

    // ======
    // external_bus_control field layout
    // ======
    localparam int         BIT_RELEASE       = 7;      // bus_release_select
    localparam int         BIT_STRETCH_HI    = 5;      // cycle_stretch_hi
    localparam int         BIT_STRETCH_LO    = 4;      // cycle_stretch_lo
    localparam int         BIT_STYLE_HI      = 1;      // write_style_hi
    localparam int         BIT_STYLE_LO      = 0;      // write_style_lo
    localparam logic [7:0] CTRL_WRITE_MASK   = 8'hb3;  // bits 6, 3, 2 not implemented
    localparam logic [7:0] CTRL_RESET        = 8'h00;

    // ======
    // status register field layout
    // ======
    localparam int         STAT_BUSY         = 0;
    localparam int         STAT_OWNS_PINS    = 1;
    localparam int         STAT_WORD_HELD    = 2;
    localparam int         STAT_LOCKED       = 3;

    // ======
    // timing
    // ======
    localparam int         TCY_CLKS_DEFAULT  = 4;      // clock edges per instruction cycle
    localparam logic [1:0] STRETCH_MAX_TCY   = 2'h3;   // code 00 adds three cycles

    // write styles on a 16-bit bus
    typedef enum logic [1:0] {
        STYLE_BYTE_WRITE  = 2'h0,
        STYLE_BYTE_SELECT = 2'h1,
        STYLE_WORD_A      = 2'h2,
        STYLE_WORD_B      = 2'h3
    } write_style_t;

    // one table access as handed over by the core
    typedef struct packed {
        logic        write;
        logic        high_byte;
        logic [7:0]  data;
        logic [19:0] addr;
    } table_req_t;

    // strobes that go to the external bus
    typedef struct packed {
        logic upper_write;
        logic lower_write;
        logic upper_select;
        logic lower_select;
        logic read;
    } bus_strobes_t;

    localparam bus_strobes_t STROBES_IDLE = '0;

endpackage : ext_bus_pkg

// >>> core/stretch_timer.sv
// cycle timer that holds the active part of a bus cycle for base plus wait instruction cycles
`timescale 1ns/1ps

module stretch_timer #(
    parameter int TCY_CLKS = ext_bus_pkg::TCY_CLKS_DEFAULT
) (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       start_in,
    input  wire logic [1:0] wait_tcy_in,
    output logic            done_out
);

    localparam int CNT_W = $clog2(TCY_CLKS * 4 + 1);

    logic [CNT_W-1:0] remain_r;
    logic             running_r;
    logic [CNT_W-1:0] load_val;

    // base instruction cycle plus the added wait cycles, all in clock edges
    assign load_val = CNT_W'((32'(wait_tcy_in) + 32'd1) * TCY_CLKS - 1);

    // count down; done fires in the last clock of the stretched strobe
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            remain_r  <= '0;
            running_r <= 1'b0;
        end else if (start_in) begin
            remain_r  <= load_val;
            running_r <= 1'b1;
        end else if (running_r && remain_r != '0) begin
            remain_r  <= remain_r - CNT_W'(1);
        end else begin
            running_r <= 1'b0;
        end
    end

    assign done_out = running_r && (remain_r == '0);

endmodule : stretch_timer

// >>> dv/ext_mem_model.sv
// far-side memory: one word-wide device or two byte-wide devices
`timescale 1ns/1ps

module ext_mem_model (
    input  wire logic        clk_in,
    input  wire logic        word_mem_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [15:0] data_in,
    input  wire logic        read_strobe_in,
    input  wire logic        upper_write_in,
    input  wire logic        lower_write_in,
    input  wire logic        upper_select_in,
    input  wire logic        lower_select_in,
    output logic      [15:0] data_out
);
    logic [15:0] mem [int];
    logic [15:0] drv_r = 16'h5a5a;
    logic        lo_we;
    int          k;
    assign data_out = drv_r;
    // a word device takes the upper strobe on both lanes unless a byte select narrows it
    always @(posedge clk_in) begin
        k = int'(addr_in[19:1]);
        lo_we = lower_write_in || (upper_write_in && (lower_select_in ||
                (word_mem_in && !upper_select_in)));
        if (!mem.exists(k))
            mem[k] = 16'h0000;
        if (lo_we)
            mem[k][7:0] = data_in[7:0];
        if (upper_write_in && !lower_select_in)
            mem[k][15:8] = data_in[15:8];
        // an idle bus holds no value: the inverse makes an early sample show up
        drv_r <= read_strobe_in ? mem[k] : ~drv_r;
    end
endmodule : ext_mem_model

// >>> dv/ext_bus_ctrl_asserts.sv
// concurrent checks on the external memory bus control ports
`timescale 1ns/1ps

module ext_bus_ctrl_asserts #(
    parameter int TCY_CLKS = 4
) (
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        single_chip_mode_in,
    input wire logic        small_package_in,
    input wire logic        bus_16bit_in,
    input wire logic        busy_out,
    input wire logic        read_valid_out,
    input wire logic [15:0] ext_data_out,
    input wire logic        bus_owns_pins_out,
    input wire logic        read_strobe_out,
    input wire logic        upper_write_strobe_out,
    input wire logic        lower_write_strobe_out,
    input wire logic        upper_byte_select_out,
    input wire logic        lower_byte_select_out
);
    // ======
    // helper state
    logic [7:0] ctrl_r;
    logic [4:0] run_r;
    wire        uw = upper_write_strobe_out;
    wire        lw = lower_write_strobe_out;
    wire        wr = uw | lw;
    wire        stb = wr | read_strobe_out;
    wire        cp = ext_data_out[15:8] == ext_data_out[7:0];
    wire        sel1 = upper_byte_select_out ^ lower_byte_select_out;
    // shadow of the control register; a locked or absent register drops writes
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in)
            ctrl_r <= 8'h00;
        else if (reg_wr_in && reg_addr_in == 4'h0 && !single_chip_mode_in && !small_package_in)
            ctrl_r <= reg_wdata_in & ext_bus_pkg::CTRL_WRITE_MASK;
    end
    // length of the current strobe run, read when the run ends
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in)
            run_r <= 5'h00;
        else
            run_r <= stb ? run_r + 5'h01 : 5'h00;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // ======
    // assertions
    // ownership follows the release bit one cycle after the register takes it
    chk_bus_default: assert property (!ctrl_r[7] && !$past(ctrl_r[7])
        |-> bus_owns_pins_out) else $error("pins released while release bit clear");
    chk_pins_released: assert property (ctrl_r[7] && $past(ctrl_r[7]) && !stb
        && !busy_out && !$past(busy_out) |-> !bus_owns_pins_out)
        else $error("idle bus holds pins");
    chk_strobe_owns: assert property (stb |-> bus_owns_pins_out)
        else $error("strobe without pin ownership");
    chk_stretch_count: assert property ($fell(stb)
        |-> int'(run_r) == (4 - int'(ctrl_r[5:4])) * TCY_CLKS) else $error("bad strobe length");
    chk_read_valid: assert property ($fell(read_strobe_out) |-> read_valid_out)
        else $error("no read result after strobe");
    chk_narrow_lane: assert property (!bus_16bit_in && wr |-> lw && !uw)
        else $error("8-bit write on wrong strobe");
    chk_word_strobe: assert property (bus_16bit_in && ctrl_r[1] && wr |-> uw && !lw)
        else $error("word write strobe wrong");
    chk_select_style: assert property (bus_16bit_in && ctrl_r[1:0] == 2'h1 && wr
        |-> uw && !lw && sel1 && cp) else $error("byte select write wrong");
    chk_byte_style: assert property (bus_16bit_in && ctrl_r[1:0] == 2'h0 && wr
        |-> (uw ^ lw) && cp) else $error("byte write wrong");
    chk_ctrl_readback: assert property (reg_rd_in && reg_addr_in == 4'h0 && !small_package_in
        |=> reg_rdata_out == ctrl_r) else $error("control readback wrong");
    chk_absent_reads: assert property (reg_rd_in && reg_addr_in == 4'h0 && small_package_in
        |=> reg_rdata_out == 8'h00) else $error("absent register not zero");
    cov_read_done: cover property (read_valid_out);
    cov_word_write: cover property (bus_16bit_in && ctrl_r[1] && uw);
    cov_released_access: cover property (ctrl_r[7] && stb);
endmodule : ext_bus_ctrl_asserts

bind ext_bus_ctrl ext_bus_ctrl_asserts #(.TCY_CLKS(TCY_CLKS)) u_asserts (.*);

// >>> dv/ext_bus_ctrl_bench.sv
// self-checking bench for the external memory bus control block
`timescale 1ns/1ps
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module ext_bus_ctrl_bench;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        single_chip_mode_in = 1'b0;
    logic        small_package_in = 1'b0;
    logic        bus_16bit_in = 1'b0;
    logic        table_read_op_in = 1'b0;
    logic        table_write_op_in = 1'b0;
    logic [19:0] table_addr_in = 20'h00000;
    logic [7:0]  table_latch_byte_in = 8'h00;
    logic        word_mem = 1'b0;
    logic [15:0] ext_data_in, ext_data_out, lfsr = 16'h8722;
    logic [19:0] ext_addr_out;
    logic [7:0]  reg_rdata_out, read_data_out, held, got;
    logic        busy_out, read_valid_out, ext_data_oe_n_out, bus_owns_pins_out;
    logic        read_strobe_out, upper_write_strobe_out, lower_write_strobe_out;
    logic        upper_byte_select_out, lower_byte_select_out;
    logic [15:0] mem_m [int];
    int          n_errors = 0;
    int          n_tests = 0;

    always #10 clk_in = ~clk_in;
    // a two-clock instruction cycle keeps every stretched access short
    ext_bus_ctrl #(.ADDR_W(20), .TCY_CLKS(2)) u_dut (
        .clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .single_chip_mode_in, .small_package_in, .bus_16bit_in, .table_read_op_in,
        .table_write_op_in, .table_addr_in, .table_latch_byte_in, .busy_out, .read_data_out,
        .read_valid_out, .ext_data_in, .ext_data_out, .ext_data_oe_n_out, .ext_addr_out,
        .bus_owns_pins_out, .read_strobe_out, .upper_write_strobe_out, .lower_write_strobe_out,
        .upper_byte_select_out, .lower_byte_select_out
    );
    ext_mem_model u_mem (
        .clk_in, .word_mem_in(word_mem), .addr_in(ext_addr_out), .data_in(ext_data_out),
        .read_strobe_in(read_strobe_out), .upper_write_in(upper_write_strobe_out),
        .lower_write_in(lower_write_strobe_out), .upper_select_in(upper_byte_select_out),
        .lower_select_in(lower_byte_select_out), .data_out(ext_data_in)
    );

    // ======
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : reg_read
    // one table access; waits on busy with a bound and keeps the read result
    task automatic table_op(input logic wr, input logic [19:0] a, input logic [7:0] b);
        logic w;
        got = 8'hxx;
        @(posedge clk_in);
        table_write_op_in <= wr;
        table_read_op_in <= !wr;
        table_addr_in <= a;
        table_latch_byte_in <= b;
        @(posedge clk_in);
        table_write_op_in <= 1'b0;
        table_read_op_in <= 1'b0;
        #1;
        for (int i = 0; i < 64 && busy_out === 1'b1; i++) begin
            if (read_valid_out === 1'b1)
                got = read_data_out;
            // data drivers are on only while a write strobe stands
            w = upper_write_strobe_out | lower_write_strobe_out;
            `CHECK(ext_data_oe_n_out, !(wr && w))
            @(posedge clk_in);
            #1;
        end
    endtask : table_op
    // memory as the far side should hold it after a table write
    task automatic model_write(input logic [19:0] a, input logic [7:0] b, input logic [7:0] c);
        int          k;
        logic [15:0] w;
        k = int'(a[19:1]);
        w = mem_m.exists(k) ? mem_m[k] : 16'h0000;
        if (!bus_16bit_in)
            w[7:0] = b;
        else if (c[1] && !a[0])
            held = b;
        else if (c[1])
            w = {b, held};
        else if (a[0])
            w[15:8] = b;
        else
            w[7:0] = b;
        mem_m[k] = w;
    endtask : model_write
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // ======
    // main sequence: register access first, then every wait, style and width
    initial begin
        logic [7:0]  c, d, b;
        logic [19:0] a;
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        #1 `CHECK(bus_owns_pins_out, 1'b1)
        reg_read(4'h0, d);
        `CHECK(d, 8'h00)
        reg_read(4'h1, d);
        `CHECK(d, 8'h02)
        reg_write(4'h0, 8'hff);
        reg_read(4'h0, d);
        `CHECK(d, 8'hb3)
        @(posedge clk_in);
        single_chip_mode_in <= 1'b1;
        reg_write(4'h0, 8'h00);
        reg_read(4'h0, d);
        `CHECK(d, 8'hb3)
        @(posedge clk_in);
        single_chip_mode_in <= 1'b0;
        small_package_in <= 1'b1;
        reg_write(4'h0, 8'h00);
        reg_read(4'h0, d);
        `CHECK(d, 8'h00)
        @(posedge clk_in);
        small_package_in <= 1'b0;
        reg_read(4'h0, d);
        `CHECK(d, 8'hb3)
        reg_read(4'hf, d);
        `CHECK(d, 8'h00)
        for (int i = 0; i < 32; i++) begin
            lfsr = lfsr_next(lfsr);
            c = {lfsr[0], 1'b0, i[1:0], 2'b00, i[3:2]};
            @(posedge clk_in);
            bus_16bit_in <= i[4];
            word_mem <= i[3];
            reg_write(4'h0, c | 8'h4c); // unimplemented bits set on purpose
            reg_read(4'h0, d);
            `CHECK(d, c)
            `CHECK(bus_owns_pins_out, ~c[7])
            a = {4'h0, lfsr[15:1], 1'b0};
            lfsr = lfsr_next(lfsr);
            for (int j = 0; j < 2; j++) begin
                b = j[0] ? lfsr[15:8] : lfsr[7:0];
                table_op(1'b1, {a[19:1], j[0]}, b);
                model_write({a[19:1], j[0]}, b, c);
            end
            for (int j = 0; j < 2; j++) begin
                table_op(1'b0, {a[19:1], j[0]}, 8'h00);
                d = (bus_16bit_in && j[0]) ? mem_m[int'(a[19:1])][15:8] : mem_m[int'(a[19:1])][7:0];
                `CHECK(got, d)
            end
        end
        finish_test();
    end

    // watchdog well beyond the fewer than two thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        finish_test();
    end
endmodule : ext_bus_ctrl_bench
